/* include/clock_gear_pkg.sv */
// Constants, field layouts and carrier types for the reset and clock gear control block.
// Assumes a single 25 MHz clock and a 32-bit register port with byte addresses.
package clock_gear_pkg;

  // Register window base and byte offsets
  localparam logic [31:0] CG_BASE_ADDR = 32'h4004_0200;
  localparam logic [31:0] OFS_SYSTEM_CONFIG = 32'h0000_0000;
  localparam logic [31:0] OFS_OSC_WARMUP = 32'h0000_0004;
  localparam logic [31:0] OFS_STANDBY = 32'h0000_0008;
  localparam logic [31:0] OFS_MULT_SELECT = 32'h0000_000C;
  localparam logic [31:0] OFS_RESERVED = 32'h0000_0010;
  localparam logic [31:0] ADDR_SYSTEM_CONFIG = CG_BASE_ADDR + OFS_SYSTEM_CONFIG;
  localparam logic [31:0] ADDR_OSC_WARMUP = CG_BASE_ADDR + OFS_OSC_WARMUP;
  localparam logic [31:0] ADDR_STANDBY = CG_BASE_ADDR + OFS_STANDBY;
  localparam logic [31:0] ADDR_MULT_SELECT = CG_BASE_ADDR + OFS_MULT_SELECT;
  localparam logic [31:0] ADDR_RESERVED = CG_BASE_ADDR + OFS_RESERVED;

  // Field positions
  localparam int PERIPH_SRC_BIT = 12;
  localparam int PRESCALE_LSB = 8;
  localparam int GEAR_LSB = 0;
  localparam int WARMUP_VAL_LSB = 20;
  localparam int WARMUP_VAL_W = 12;
  localparam int HS_OSC_BIT = 8;
  localparam int WARMUP_SRC_BIT = 3;
  localparam int MULT_RUN_BIT = 2;
  localparam int WARMUP_BUSY_BIT = 1;
  localparam int WARMUP_START_BIT = 0;
  localparam int MULT_SELECT_BIT = 0;

  // Reset values
  localparam logic [31:0] SYS_RESET = 32'h0001_0000;
  localparam logic [31:0] OSC_RESET = 32'h8001_0100;
  localparam logic [31:0] STBY_RESET = 32'h0000_0103;
  localparam logic [31:0] MSEL_RESET = 32'h0000_A13E;

  // Bits that hold written values; all others read as zero, except the live warm-up busy bit
  localparam logic [31:0] SYS_WMASK = 32'h0003_1707;
  localparam logic [31:0] OSC_WMASK = 32'hFFFF_F30C;
  localparam logic [31:0] STBY_WMASK = 32'h0003_0307;
  localparam logic [31:0] MSEL_WMASK = 32'h0000_F7FF;

  // Gear codes, and the highest legal prescaler code
  localparam logic [2:0] GEAR_DIV1 = 3'h0;
  localparam logic [2:0] GEAR_DIV2 = 3'h4;
  localparam logic [2:0] PRESCALE_MAX = 3'h5;

  // Fixed facts presented to the rest of the chip
  localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0004;
  localparam logic [3:0] MULTIPLIER_RATIO = 4'h8;

  // Timing: least low time of the external reset pin
  localparam int CLK_PERIOD_NS = 40;
  localparam int PIN_LOW_MIN_NS = 1200;
  localparam int PIN_LOW_MIN_CYC = (PIN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRETCH_W = 6;

  // Warm-up timer states, one-hot
  typedef enum logic [1:0] {
    WU_IDLE = 2'b01,
    WU_COUNT = 2'b10
  } warmup_fsm_t;

  // Clock tree selects
  typedef struct packed {
    logic periph_from_fc;
    logic [2:0] prescale_shift;
    logic [2:0] gear_shift;
  } clock_tree_sel_t;

  // Oscillator and multiplier enables
  typedef struct packed {
    logic hs_osc_enable;
    logic multiplier_run;
    logic pll_selected;
  } osc_ctrl_t;

  // True for gear codes that name a divider
  function automatic logic gear_code_ok(input logic [2:0] code);
    gear_code_ok = (code == GEAR_DIV1) || (code >= GEAR_DIV2);
  endfunction : gear_code_ok

  // True for prescaler codes that name a divider
  function automatic logic prescale_code_ok(input logic [2:0] code);
    prescale_code_ok = (code <= PRESCALE_MAX);
  endfunction : prescale_code_ok

endpackage : clock_gear_pkg

/* logic/reset_conditioner.sv */
// Synchronises the external reset pin and stretches it into the block's core reset.
// Assumes rst_b is the on-chip power-on reset, synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module reset_conditioner (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic reset_pin_b,
  output logic core_reset,
  output logic state_defined
);

  localparam int STRETCH_W = clock_gear_pkg::STRETCH_W;

  // All state of the conditioner
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [STRETCH_W-1:0] stretch;
    logic core_reset;
    logic seen_low;
  } rc_state_t;

  localparam logic [STRETCH_W-1:0] STRETCH_LOAD = STRETCH_W'(clock_gear_pkg::PIN_LOW_MIN_CYC - 1);

  rc_state_t st;
  rc_state_t next_st;

  // Next state: sync first, then stretch a short low to the least reset length
  always_comb
  begin
    next_st = st;
    next_st.sync1 = reset_pin_b;
    next_st.sync2 = st.sync1;
    if (!st.sync2)
    begin
      // A low of any length resets; the stretch covers glitches shorter than legal [RL2] [RL4]
      next_st.stretch = STRETCH_LOAD;
    end
    else if (st.stretch != '0)
    begin
      next_st.stretch = st.stretch - STRETCH_W'(1);
    end
    // Whole block returns to reset values; no memory content survives [RL5] [RL8]
    next_st.core_reset = !st.sync2 || (st.stretch != '0);
    // Register contents only count as defined once the pin has gone low [RL3]
    next_st.seen_low = st.seen_low || !st.sync2;
  end

  // Power-on reset needs no pin activity at all [RL1]
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st <= '{sync1: 1'b1, sync2: 1'b1, stretch: '0, core_reset: 1'b0, seen_low: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign core_reset = st.core_reset;
  assign state_defined = st.seen_low;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_pin_low_resets: assert property (!st.sync2 |=> core_reset [*2]) // [RL5]
    else $error("Core reset not held after pin low");
  a_defined_cause: assert property ($rose(state_defined) |-> $past(!st.sync2)) // [RL3]
    else $error("State marked defined without a pin reset");
  c_pin_reset: cover property ($fell(core_reset));

endmodule : reset_conditioner
`default_nettype wire

/* logic/warmup_timer.sv */
// Warm-up timer: counts the programmed number of mclk cycles after a start.
// Assumes start is a one-cycle pulse from register logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module warmup_timer #(
  parameter int WIDTH = 12
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic start,
  input wire logic [WIDTH-1:0] duration,
  output logic busy
);

  // All state of the timer
  typedef struct packed {
    clock_gear_pkg::warmup_fsm_t fsm;
    logic [WIDTH-1:0] count;
  } wu_state_t;

  wu_state_t st;
  wu_state_t next_st;

  // Next state; a start with a nonzero duration always wins, even on the cycle the count expires
  always_comb
  begin
    next_st = st;
    case (st.fsm)
      clock_gear_pkg::WU_IDLE:
      begin
        next_st.count = '0;
      end
      clock_gear_pkg::WU_COUNT:
      begin
        // Expire after exactly duration cycles of busy [RL21]
        next_st.count = st.count - WIDTH'(1);
        if (st.count == WIDTH'(1))
        begin
          next_st.fsm = clock_gear_pkg::WU_IDLE;
        end
      end
      default:
      begin
        next_st.fsm = clock_gear_pkg::WU_IDLE;
      end
    endcase
    // A zero duration is already complete, so it never raises busy [RL17]
    if (start && (duration != '0))
    begin
      next_st.fsm = clock_gear_pkg::WU_COUNT;
      next_st.count = duration;
    end
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (!rst_b || soft_reset)
    begin
      st <= '{fsm: clock_gear_pkg::WU_IDLE, count: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign busy = (st.fsm == clock_gear_pkg::WU_COUNT); // [RL16]

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b || soft_reset);

  a_busy_ends: assert property (busy && st.count == WIDTH'(1) && !start |=> !busy) // [RL21]
    else $error("Warm-up busy outlived its count");
  a_busy_holds: assert property (start && duration == WIDTH'(3) |=> busy [*3] ##1 (!busy || $past(start)))
    else $error("Warm-up busy length wrong"); // [RL16]
  c_warmup_done: cover property ($fell(busy));

endmodule : warmup_timer
`default_nettype wire

/* logic/reset_and_clock_gear_control.sv */
// Reset handling and clock gear / oscillator control registers.
// Assumes a one-cycle strobe register port on mclk and an asynchronous reset pin.
//
// How it works
// RL1 - Power-on reset needs no external pulse.
// RL2 - External reset pin held low 1.2 us.
// RL3 - State undefined until pin driven low.
// RL4 - Power may rise with pin already low.
// RL5 - Reset release restores all register reset values.
// RL6 - Multiplier stopped after reset until programmed.
// RL7 - Reset handler address held at 0x0000_0004.
// RL8 - Memory contents not kept across reset.
// RL9 - Registers decoded at base plus four offsets.
// RL10 - Bit 12 picks peripheral clock source.
// RL11 - Bits 10-8 pick prescaler divide.
// RL12 - Bits 2-0 pick high-speed clock gear.
// RL13 - Bits 31-20 hold warm-up count value.
// RL14 - Bit 8 enables high-speed oscillator.
// RL15 - Bit 2 runs multiplier, resets stopped.
// RL16 - Bit 1 reads warm-up busy flag.
// RL17 - Bit 0 write one starts warm-up.
// RL18 - Software writes zero to warm-up source.
// RL19 - Select bit picks oscillator or multiplier.
// RL20 - Multiplier output is eight times oscillator.
// RL21 - Busy stays high for programmed count.
// RL22 - Reserved bits read zero, constants stored.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module reset_and_clock_gear_control (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic reset_pin_b,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output clock_gear_pkg::clock_tree_sel_t clock_tree,
  output clock_gear_pkg::osc_ctrl_t osc_ctrl,
  output logic [3:0] multiplier_ratio,
  output logic [31:0] boot_vector_addr,
  output logic warmup_busy,
  output logic core_reset,
  output logic state_defined
);

  // All state of the register block
  typedef struct packed {
    logic [31:0] sys;
    logic [31:0] osc;
    logic [31:0] stby;
    logic [31:0] msel;
    logic [31:0] rdata;
    clock_gear_pkg::clock_tree_sel_t tree;
    clock_gear_pkg::osc_ctrl_t ctl;
    logic [3:0] ratio;
    logic [31:0] vector;
  } cg_state_t;

  // Every field at its reset value
  localparam cg_state_t ST_RESET = '{
    sys: clock_gear_pkg::SYS_RESET,
    osc: clock_gear_pkg::OSC_RESET,
    stby: clock_gear_pkg::STBY_RESET,
    msel: clock_gear_pkg::MSEL_RESET,
    rdata: 32'h0000_0000,
    tree: '0,
    ctl: '{hs_osc_enable: 1'b1, multiplier_run: 1'b0, pll_selected: 1'b0},
    ratio: clock_gear_pkg::MULTIPLIER_RATIO,
    vector: clock_gear_pkg::RESET_VECTOR_ADDR
  };

  localparam int WU_W = clock_gear_pkg::WARMUP_VAL_W;

  cg_state_t st;
  cg_state_t next_st;
  logic block_reset; // Either reset source
  logic wu_start; // One-cycle warm-up start
  logic [WU_W-1:0] wu_duration; // Duration taken with the start
  logic [2:0] new_gear; // Gear code offered by a write
  logic [2:0] new_prescale; // Prescaler code offered by a write

  // Pin synchroniser and reset stretcher
  reset_conditioner u_reset (
    .mclk (mclk),
    .rst_b (rst_b),
    .reset_pin_b (reset_pin_b),
    .core_reset (core_reset),
    .state_defined (state_defined)
  );

  // Warm-up counter
  warmup_timer #(
    .WIDTH (WU_W)
  ) u_warmup (
    .mclk (mclk),
    .rst_b (rst_b),
    .soft_reset (core_reset),
    .start (wu_start),
    .duration (wu_duration),
    .busy (warmup_busy)
  );

  assign block_reset = !rst_b || core_reset;

  // Start pulse comes straight from the write so busy rises the next cycle
  assign wu_start = reg_wr && (reg_addr == clock_gear_pkg::ADDR_OSC_WARMUP)
    && reg_wdata[clock_gear_pkg::WARMUP_START_BIT]; // [RL17]
  assign wu_duration = reg_wdata[clock_gear_pkg::WARMUP_VAL_LSB +: WU_W]; // [RL13]
  assign new_gear = reg_wdata[clock_gear_pkg::GEAR_LSB +: 3];
  assign new_prescale = reg_wdata[clock_gear_pkg::PRESCALE_LSB +: 3];

  // Register writes, read data and the clock tree selects
  always_comb
  begin
    next_st = st;
    next_st.rdata = 32'h0000_0000;
    // Writes
    if (reg_wr)
    begin
      if (reg_addr == clock_gear_pkg::ADDR_SYSTEM_CONFIG)
      begin
        // Source bit and the stored constant bits take the written value [RL10] [RL22]
        next_st.sys = reg_wdata & clock_gear_pkg::SYS_WMASK;
        // A reserved code would leave the tree without a divider, so it is dropped
        if (!clock_gear_pkg::prescale_code_ok(new_prescale))
        begin
          next_st.sys[clock_gear_pkg::PRESCALE_LSB +: 3] =
            st.sys[clock_gear_pkg::PRESCALE_LSB +: 3]; // [RL11]
        end
        if (!clock_gear_pkg::gear_code_ok(new_gear))
        begin
          next_st.sys[clock_gear_pkg::GEAR_LSB +: 3] = st.sys[clock_gear_pkg::GEAR_LSB +: 3]; // [RL12]
        end
      end
      else if (reg_addr == clock_gear_pkg::ADDR_OSC_WARMUP)
      begin
        // Count value, enables and the source bit are kept; bit 0 is not stored
        next_st.osc = reg_wdata & clock_gear_pkg::OSC_WMASK; // [RL13] [RL14] [RL15] [RL18]
      end
      else if (reg_addr == clock_gear_pkg::ADDR_STANDBY)
      begin
        // Held for software only; low-power sequencing lives elsewhere
        next_st.stby = reg_wdata & clock_gear_pkg::STBY_WMASK; // [RL22]
      end
      else if (reg_addr == clock_gear_pkg::ADDR_MULT_SELECT)
      begin
        next_st.msel = reg_wdata & clock_gear_pkg::MSEL_WMASK; // [RL19]
      end
      else
      begin
        // Reserved and unmapped addresses ignore writes
        next_st.sys = st.sys;
      end
    end
    // Reads: data stands in the following cycle only
    if (reg_rd)
    begin
      if (reg_addr == clock_gear_pkg::ADDR_SYSTEM_CONFIG)
      begin
        next_st.rdata = st.sys; // [RL9]
      end
      else if (reg_addr == clock_gear_pkg::ADDR_OSC_WARMUP)
      begin
        // Start bit reads zero; busy is live timer state
        next_st.rdata = st.osc;
        next_st.rdata[clock_gear_pkg::WARMUP_BUSY_BIT] = warmup_busy; // [RL16]
      end
      else if (reg_addr == clock_gear_pkg::ADDR_STANDBY)
      begin
        next_st.rdata = st.stby;
      end
      else if (reg_addr == clock_gear_pkg::ADDR_MULT_SELECT)
      begin
        next_st.rdata = st.msel;
      end
      else
      begin
        // Reserved word and anything unmapped read as zero [RL22]
        next_st.rdata = 32'h0000_0000;
      end
    end
    // Peripheral source and prescaler shift follow the register directly [RL10] [RL11]
    next_st.tree.periph_from_fc = next_st.sys[clock_gear_pkg::PERIPH_SRC_BIT];
    next_st.tree.prescale_shift = next_st.sys[clock_gear_pkg::PRESCALE_LSB +: 3];
    // Gear codes 4..7 mean divide by 2..16, so the shift is code minus three [RL12]
    if (next_st.sys[clock_gear_pkg::GEAR_LSB +: 3] == clock_gear_pkg::GEAR_DIV1)
    begin
      next_st.tree.gear_shift = 3'h0;
    end
    else
    begin
      next_st.tree.gear_shift = next_st.sys[clock_gear_pkg::GEAR_LSB +: 3] - 3'h3;
    end
    // Enables to the analogue parts
    next_st.ctl.hs_osc_enable = next_st.osc[clock_gear_pkg::HS_OSC_BIT]; // [RL14]
    next_st.ctl.multiplier_run = next_st.osc[clock_gear_pkg::MULT_RUN_BIT]; // [RL15]
    // The multiplied clock is only handed over while the multiplier runs, so a
    // select left at one after stopping falls back to the oscillator [RL6] [RL19] [RL20]
    next_st.ctl.pll_selected = next_st.msel[clock_gear_pkg::MULT_SELECT_BIT]
      && next_st.osc[clock_gear_pkg::MULT_RUN_BIT];
    // Fixed facts held in flops so they read defined from reset onward [RL7] [RL20]
    next_st.ratio = clock_gear_pkg::MULTIPLIER_RATIO;
    next_st.vector = clock_gear_pkg::RESET_VECTOR_ADDR;
  end

  // State register; both reset sources restore the documented values [RL1] [RL5] [RL6]
  always_ff @(posedge mclk)
  begin
    if (block_reset)
    begin
      st <= ST_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs, all from flops
  assign reg_rdata = st.rdata;
  assign clock_tree = st.tree;
  assign osc_ctrl = st.ctl;
  assign multiplier_ratio = st.ratio;
  assign boot_vector_addr = st.vector;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (block_reset);

  // Multiplier is off and unselected in the cycle after any reset cycle
  a_mult_off_reset: assert property (disable iff (1'b0)
    block_reset |=> (!osc_ctrl.multiplier_run && !osc_ctrl.pll_selected)) // [RL6]
    else $error("Multiplier active right after reset");
  a_gear_code_legal: assert property (clock_gear_pkg::gear_code_ok(st.sys[2:0])
    && clock_tree.gear_shift <= 3'h4) // [RL12]
    else $error("Gear field holds a reserved code");
  a_prescale_legal: assert property (reg_wr && reg_addr == clock_gear_pkg::ADDR_SYSTEM_CONFIG
    && !clock_gear_pkg::prescale_code_ok(new_prescale) |=> $stable(clock_tree.prescale_shift))
    else $error("Reserved prescaler code took effect"); // [RL11]
  a_periph_src_write: assert property (reg_wr && reg_addr == clock_gear_pkg::ADDR_SYSTEM_CONFIG
    |=> clock_tree.periph_from_fc == $past(reg_wdata[12])) // [RL10]
    else $error("Peripheral source select did not follow write");
  a_osc_enable_write: assert property (reg_wr && reg_addr == clock_gear_pkg::ADDR_OSC_WARMUP
    |=> osc_ctrl.hs_osc_enable == $past(reg_wdata[8])) // [RL14]
    else $error("Oscillator enable did not follow write");
  a_start_sets_busy: assert property (wu_start && wu_duration != '0 |=> warmup_busy) // [RL17]
    else $error("Warm-up start did not raise busy");
  a_busy_readback: assert property (reg_rd && reg_addr == clock_gear_pkg::ADDR_OSC_WARMUP
    |=> reg_rdata[1] == $past(warmup_busy) && reg_rdata[0] == 1'b0) // [RL16]
    else $error("Busy flag readback wrong");
  a_reserved_reads: assert property (reg_rd && reg_addr == clock_gear_pkg::ADDR_RESERVED
    |=> reg_rdata == 32'h0000_0000 ##1 (reg_rdata == 32'h0000_0000 || $past(reg_rd))) // [RL22]
    else $error("Reserved word read nonzero");
  a_msel_readback: assert property (reg_wr && reg_addr == clock_gear_pkg::ADDR_MULT_SELECT
    ##1 reg_rd && reg_addr == clock_gear_pkg::ADDR_MULT_SELECT
    |=> reg_rdata == ($past(reg_wdata, 2) & clock_gear_pkg::MSEL_WMASK)) // [RL9] [RL19]
    else $error("Multiplier select readback wrong");
  a_vector_fixed: assert property (boot_vector_addr == 32'h0000_0004 && multiplier_ratio == 4'h8)
    else $error("Reset vector or ratio wrong"); // [RL7]

  c_pll_in_use: cover property (osc_ctrl.pll_selected);
  c_gear_div16: cover property (clock_tree.gear_shift == 3'h4);
  c_warmup_run: cover property (wu_start ##1 warmup_busy [*2]);

endmodule : reset_and_clock_gear_control
`default_nettype wire

/* bench/reset_and_clock_gear_control_tb.sv */
// Self-checking bench for the reset and clock gear control block.
// Assumes the clock gear package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module reset_and_clock_gear_control_tb;
  logic mclk = 1'h0; // 25 MHz clock
  logic rst_b = 1'h0; // Power-on reset, active low
  logic reset_pin_b = 1'h1; // External reset pin, idle high
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  clock_gear_pkg::clock_tree_sel_t clock_tree;
  clock_gear_pkg::osc_ctrl_t osc_ctrl;
  logic [3:0] multiplier_ratio;
  logic [31:0] boot_vector_addr;
  logic warmup_busy;
  logic core_reset;
  logic state_defined;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic rd_seen = 1'h0; // A read was taken at the last edge
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0; // Cycle count for the hang limit
  logic [31:0] sys_m, osc_m, msel_m, d, nxt; // Register models and scratch
  int n;

  always #20 mclk = ~mclk;

  reset_and_clock_gear_control DUT (.mclk(mclk), .rst_b(rst_b), .reset_pin_b(reset_pin_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clock_tree(clock_tree), .osc_ctrl(osc_ctrl),
    .multiplier_ratio(multiplier_ratio), .boot_vector_addr(boot_vector_addr),
    .warmup_busy(warmup_busy), .core_reset(core_reset), .state_defined(state_defined));

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One-cycle write strobe; the idle edge after it keeps strobes from merging
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask : wr

  // One-cycle read strobe; the expected word is noted for the monitor
  task automatic rd(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    exp_q.push_back(v);
    @(posedge mclk);
    reg_rd <= 1'h0;
  endtask : rd

  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Expected clock tree selects from a system config word
  function automatic clock_gear_pkg::clock_tree_sel_t tree_of(input logic [31:0] s);
    tree_of.periph_from_fc = s[12];
    tree_of.prescale_shift = s[10:8];
    tree_of.gear_shift = (s[2:0] == 3'h0) ? 3'h0 : s[2:0] - 3'h3;
  endfunction : tree_of

  // Note taken reads and cut a hang short
  always @(posedge mclk)
  begin
    rd_seen <= reg_rd;
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      end_sim();
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise
  always @(negedge mclk)
  begin
    if (rd_seen === 1'h1 && exp_q.size() > 0)
      chk(reg_rdata, exp_q.pop_front(), "read data");
    else if (rst_b === 1'h1)
      chk(reg_rdata, 32'h0, "idle read data");
  end

  initial
  begin
    void'($urandom(32'hEF78));
    sys_m = clock_gear_pkg::SYS_RESET;
    msel_m = clock_gear_pkg::MSEL_RESET;
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    // Reset values, reserved and unmapped places
    @(negedge mclk);
    chk({25'h0, clock_tree}, 32'h0, "tree reset");
    chk({29'h0, osc_ctrl}, 32'h4, "osc reset");
    chk(boot_vector_addr, 32'h0000_0004, "vector");
    chk({28'h0, multiplier_ratio}, 32'h8, "ratio");
    chk({31'h0, state_defined}, 32'h0, "defined");
    rd(clock_gear_pkg::ADDR_SYSTEM_CONFIG, clock_gear_pkg::SYS_RESET);
    rd(clock_gear_pkg::ADDR_OSC_WARMUP, clock_gear_pkg::OSC_RESET);
    rd(clock_gear_pkg::ADDR_STANDBY, clock_gear_pkg::STBY_RESET);
    rd(clock_gear_pkg::ADDR_MULT_SELECT, clock_gear_pkg::MSEL_RESET);
    wr(clock_gear_pkg::ADDR_RESERVED, 32'hFFFF_FFFF);
    rd(clock_gear_pkg::ADDR_RESERVED, 32'h0);
    rd(32'h4004_0240, 32'h0);
    $display("test reset_values done");
    // Every gear and prescaler code, descending so reserved gear codes meet a live value
    for (int i = 7; i >= 0; i--)
    begin
      d = $urandom();
      d[10:8] = i[2:0];
      d[2:0] = i[2:0];
      nxt = d & clock_gear_pkg::SYS_WMASK;
      if (i > 5)
        nxt[10:8] = sys_m[10:8];
      if (i >= 1 && i <= 3)
        nxt[2:0] = sys_m[2:0];
      sys_m = nxt;
      wr(clock_gear_pkg::ADDR_SYSTEM_CONFIG, d);
      @(negedge mclk);
      chk({25'h0, clock_tree}, {25'h0, tree_of(sys_m)}, "tree");
      rd(clock_gear_pkg::ADDR_SYSTEM_CONFIG, sys_m);
    end
    $display("test gear_codes done");
    // Oscillator, multiplier run and select combinations; source select kept zero
    for (int k = 0; k < 4; k++)
    begin
      d = {clock_gear_pkg::MSEL_RESET[31:1], k[1]};
      msel_m = d & clock_gear_pkg::MSEL_WMASK;
      wr(clock_gear_pkg::ADDR_MULT_SELECT, d);
      d = 32'h000E_0000 | {23'h0, k[0] ^ k[1], 5'h0, k[0], 2'h0};
      osc_m = d & clock_gear_pkg::OSC_WMASK;
      wr(clock_gear_pkg::ADDR_OSC_WARMUP, d);
      @(negedge mclk);
      chk({29'h0, osc_ctrl}, {29'h0, osc_m[8], osc_m[2], msel_m[0] & osc_m[2]}, "osc");
      rd(clock_gear_pkg::ADDR_MULT_SELECT, msel_m);
    end
    // Back-to-back write then read of the select word, with no idle cycle between
    d = clock_gear_pkg::MSEL_RESET;
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= clock_gear_pkg::ADDR_MULT_SELECT;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h1;
    exp_q.push_back(d & clock_gear_pkg::MSEL_WMASK);
    @(posedge mclk);
    reg_rd <= 1'h0;
    $display("test osc_controls done");
    // Warm-up: busy for exactly the programmed count
    n = 2 + ($urandom() % 6);
    d = 32'h000E_0101 | (32'(n) << 20);
    wr(clock_gear_pkg::ADDR_OSC_WARMUP, d);
    repeat (n)
    begin
      @(negedge mclk);
      chk({31'h0, warmup_busy}, 32'h1, "busy");
    end
    @(negedge mclk);
    chk({31'h0, warmup_busy}, 32'h0, "busy end");
    // Long count: the flag reads back, the start bit reads zero
    d = 32'h014E_0101;
    osc_m = d & clock_gear_pkg::OSC_WMASK;
    wr(clock_gear_pkg::ADDR_OSC_WARMUP, d);
    rd(clock_gear_pkg::ADDR_OSC_WARMUP, osc_m | 32'h2);
    for (int w = 0; w < 40 && warmup_busy !== 1'h0; w++)
      @(negedge mclk);
    wr(clock_gear_pkg::ADDR_OSC_WARMUP, d & 32'hFFFF_FFFE);
    @(negedge mclk);
    chk({31'h0, warmup_busy}, 32'h0, "no start on zero");
    rd(clock_gear_pkg::ADDR_OSC_WARMUP, osc_m);
    $display("test warmup done");
    // External pin reset: writes lost, registers back to reset values
    @(posedge mclk);
    reset_pin_b <= 1'h0;
    repeat (30) @(posedge mclk);
    reset_pin_b <= 1'h1;
    @(negedge mclk);
    chk({31'h0, core_reset}, 32'h1, "pin reset");
    chk({31'h0, state_defined}, 32'h1, "defined");
    wr(clock_gear_pkg::ADDR_SYSTEM_CONFIG, 32'h0001_1104);
    for (int w = 0; w < 200 && core_reset !== 1'h0; w++)
      @(negedge mclk);
    chk({31'h0, core_reset}, 32'h0, "pin reset end");
    chk({25'h0, clock_tree}, 32'h0, "tree after pin");
    chk({29'h0, osc_ctrl}, 32'h4, "osc after pin");
    rd(clock_gear_pkg::ADDR_SYSTEM_CONFIG, clock_gear_pkg::SYS_RESET);
    rd(clock_gear_pkg::ADDR_OSC_WARMUP, clock_gear_pkg::OSC_RESET);
    rd(clock_gear_pkg::ADDR_MULT_SELECT, clock_gear_pkg::MSEL_RESET);
    $display("test pin_reset done");
    repeat (3) @(posedge mclk);
    end_sim();
  end
endmodule : reset_and_clock_gear_control_tb
`default_nettype wire
